/* File: design/eam_accum_ctrl.sv */
`timescale 1ns/1ps
module eam_accum_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [eam_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Samples from the signal path, held between updates
  input wire eam_pkg::eam_phase_s total_a,
  input wire eam_pkg::eam_phase_s total_b,
  input wire eam_pkg::eam_phase_s total_c,
  input wire eam_pkg::eam_phase_s fund_a,
  input wire eam_pkg::eam_phase_s fund_b,
  input wire eam_pkg::eam_phase_s fund_c,
  // Zero-crossing detector levels, from pins
  input wire logic [2:0] zero_cross_in,
  // Results
  output logic signed [23:0] phase_b_rms_voltage,
  output logic signed [23:0] phase_b_current,
  output logic interrupt_line_0_n
);

  localparam int NCH = eam_pkg::NUM_CH;

  // Power of one phase after wiring substitution
  function automatic logic signed [47:0] phase_power(
    input eam_pkg::eam_phase_s a,
    input eam_pkg::eam_phase_s b,
    input eam_pkg::eam_phase_s c,
    input logic [1:0] wiring,
    input int idx
  );
    logic signed [23:0] v;
    logic signed [23:0] i;
    v = a.volt;
    i = a.curr;
    if (idx == 1) begin
      v = b.volt;
      i = b.curr;
      if (wiring == eam_pkg::WIRE_DELTA3) begin
        // Difference wraps at 24 bits, as the path is full scale
        v = 24'(a.volt - c.volt); // [RL1]
        i = '0; // [RL2]
      end else if (wiring == eam_pkg::WIRE_DELTA4) begin
        v = 24'(-a.volt); // [RL1]
      end
    end else if (idx == 2) begin
      v = c.volt;
      i = c.curr;
    end
    phase_power = 48'(v * i);
  endfunction : phase_power

  logic [15:0] half_cyc_reg, half_cyc_next;
  logic [15:0] comp_mode_reg, comp_mode_next;
  logic [7:0] acc_mode_reg, acc_mode_next;
  logic [7:0] lcyc_mode_reg, lcyc_mode_next;
  logic [7:0] thresh_reg, thresh_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] mask_reg, mask_next;
  logic irq_n_next;
  logic wr_pend_reg, wr_pend_next;
  logic [eam_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [31:0] rdata_next;
  logic addr_phase;
  logic [16:0] frac_reg, frac_next;
  logic tick_reg, tick_next;
  logic signed [47:0] pwr_reg [NCH];
  logic signed [47:0] pwr_next [NCH];
  logic [31:0] accum_reg [NCH];
  logic [31:0] accum_next [NCH];
  logic [31:0] energy_reg [NCH];
  logic [31:0] energy_next [NCH];
  logic [NCH-1:0] pulse_pos;
  logic [NCH-1:0] pulse_neg;
  logic [NCH-1:0] rd_clear;
  logic signed [23:0] rms_b_next, curr_b_next;
  logic [2:0] zx_meta_reg, zx_sync_reg, zx_prev_reg;
  logic [2:0] zx_pulse;
  logic period_done;
  logic cnt_restart;
  logic [1:0] wiring;
  logic [1:0] method;
  logic lc_enable;
  logic rd_clr_mode;
  logic [31:0] delta;
  logic wr_hit;
  logic aehf, faehf;
  logic [NCH-1:0] hf_flip;

  assign wiring = acc_mode_reg[eam_pkg::WIRING_LSB +: 2];
  assign method = acc_mode_reg[eam_pkg::METHOD_LSB +: 2];
  assign lc_enable = lcyc_mode_reg[eam_pkg::LC_EN_BIT]; // [RL6]
  assign rd_clr_mode = lcyc_mode_reg[eam_pkg::RDCLR_BIT];
  assign addr_phase = hsel & htrans[1] & hready;
  assign zx_pulse = zx_sync_reg ^ zx_prev_reg;
  assign wr_hit = wr_pend_reg;
  assign cnt_restart = wr_hit & (addr_reg == eam_pkg::ADDR_HALF_CYC)
                       & lc_enable; // [RL12]

  // First-stage rate and power products
  always_comb begin
    frac_next = frac_reg + eam_pkg::DIV_STEP;
    tick_next = 1'b0;
    // Fractional step keeps the long-run rate exact
    if (frac_next >= eam_pkg::DIV_MOD) begin
      frac_next = frac_next - eam_pkg::DIV_MOD;
      tick_next = 1'b1;
    end
    for (int k = 0; k < 3; k++) begin
      pwr_next[k] = phase_power(total_a, total_b, total_c, wiring, k);
      pwr_next[k+3] = phase_power(fund_a, fund_b, fund_c, wiring, k);
    end
    rms_b_next = total_b.volt;
    curr_b_next = total_b.curr;
    if (wiring == eam_pkg::WIRE_DELTA3) begin
      rms_b_next = 24'(total_a.volt - total_c.volt); // [RL2]
      curr_b_next = '0; // [RL2]
    end else if (wiring == eam_pkg::WIRE_DELTA4) begin
      rms_b_next = 24'(-total_a.volt);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frac_reg <= '0;
      tick_reg <= 1'b0;
      phase_b_rms_voltage <= '0;
      phase_b_current <= '0;
      for (int k = 0; k < NCH; k++) begin
        pwr_reg[k] <= '0;
      end
    end else begin
      frac_reg <= frac_next;
      tick_reg <= tick_next;
      phase_b_rms_voltage <= rms_b_next;
      phase_b_current <= curr_b_next;
      for (int k = 0; k < NCH; k++) begin
        pwr_reg[k] <= pwr_next[k];
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_stage1
    eam_first_stage #(
      .PW(48),
      .AW(56)
    ) u_stage1 (
      .clock(clock),
      .reset(reset),
      .tick(tick_reg),
      .power(pwr_reg[g]),
      .thresh(thresh_reg),
      .pulse_pos(pulse_pos[g]),
      .pulse_neg(pulse_neg[g])
    );
  end

  // Zero-crossing inputs: two-stage sync, then edge detect
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      zx_meta_reg <= '0;
      zx_sync_reg <= '0;
      zx_prev_reg <= '0;
    end else begin
      zx_meta_reg <= zero_cross_in;
      zx_sync_reg <= zx_meta_reg;
      zx_prev_reg <= zx_sync_reg;
    end
  end

  eam_zx_counter u_zx (
    .clock(clock),
    .reset(reset),
    .zx_pulse(zx_pulse),
    .select(lcyc_mode_reg[eam_pkg::ZERO_CROSS_PHASE_SELECT_LSB +: 3]),
    .limit(half_cyc_reg),
    .restart(cnt_restart),
    .period_done(period_done)
  );

  // Second stage and watthour registers
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      rd_clear[k] = addr_phase & ~hwrite & rd_clr_mode
                    & (haddr == eam_pkg::ADDR_ENERGY0
                       + 18'(k) * eam_pkg::ADDR_STRIDE); // [RL15]
      case (method) // [RL4]
        eam_pkg::METH_POSITIVE: delta = 32'(pulse_pos[k]);
        eam_pkg::METH_ABSOLUTE: delta = 32'(pulse_pos[k] | pulse_neg[k]);
        default: delta = pulse_neg[k] ? 32'hffffffff : 32'(pulse_pos[k]);
      endcase
      // Same pulses and weight in both modes [RL14]
      accum_next[k] = accum_reg[k] + delta; // [RL16]
      energy_next[k] = energy_reg[k];
      if (!lc_enable) begin
        energy_next[k] = accum_next[k];
      end else if (period_done) begin
        energy_next[k] = accum_next[k]; // [RL5]
        accum_next[k] = '0; // [RL17]
      end
      // Clearing read also resets accumulation in line cycle mode
      if (rd_clear[k]) begin
        energy_next[k] = '0; // [RL15]
        accum_next[k] = '0;
      end
      hf_flip[k] = energy_next[k][eam_pkg::HALF_FULL_BIT]
                   ^ energy_reg[k][eam_pkg::HALF_FULL_BIT];
    end
    aehf = |hf_flip[2:0];
    faehf = |hf_flip[NCH-1:3];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < NCH; k++) begin
        accum_reg[k] <= '0;
        energy_reg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NCH; k++) begin
        accum_reg[k] <= accum_next[k];
        energy_reg[k] <= energy_next[k];
      end
    end
  end

  // Bus, registers and interrupt
  always_comb begin
    addr_next = addr_reg;
    wr_pend_next = 1'b0;
    half_cyc_next = half_cyc_reg;
    comp_mode_next = comp_mode_reg;
    acc_mode_next = acc_mode_reg;
    lcyc_mode_next = lcyc_mode_reg;
    thresh_next = thresh_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = hrdata;
    if (addr_phase) begin
      addr_next = haddr;
      wr_pend_next = hwrite;
    end
    if (addr_phase && !hwrite) begin
      rdata_next = '0;
      case (haddr)
        eam_pkg::ADDR_EVENT_STATUS_0: rdata_next = {16'h0000, status_reg};
        eam_pkg::ADDR_EVENT_MASK_0: rdata_next = {16'h0000, mask_reg};
        eam_pkg::ADDR_HALF_CYC: rdata_next = {16'h0000, half_cyc_reg};
        eam_pkg::ADDR_COMP_MODE: rdata_next = {16'h0000, comp_mode_reg};
        eam_pkg::ADDR_ACC_MODE: rdata_next = {24'h000000, acc_mode_reg};
        eam_pkg::ADDR_LCYC_MODE: rdata_next = {24'h000000, lcyc_mode_reg};
        eam_pkg::ADDR_THRESH: rdata_next = {24'h000000, thresh_reg};
        default: begin
          for (int k = 0; k < NCH; k++) begin
            if (haddr == eam_pkg::ADDR_ENERGY0
                + 18'(k) * eam_pkg::ADDR_STRIDE) begin
              rdata_next = energy_reg[k];
            end
          end
        end
      endcase
    end
    if (wr_hit) begin
      case (addr_reg)
        eam_pkg::ADDR_EVENT_STATUS_0: begin
          status_next = status_reg & ~hwdata[15:0]; // [RL13]
        end
        eam_pkg::ADDR_EVENT_MASK_0: mask_next = hwdata[15:0] & eam_pkg::STATUS_USED;
        eam_pkg::ADDR_HALF_CYC: half_cyc_next = hwdata[15:0]; // [RL10]
        eam_pkg::ADDR_COMP_MODE: comp_mode_next = hwdata[15:0];
        eam_pkg::ADDR_ACC_MODE: acc_mode_next = hwdata[7:0]; // [RL1] [RL4]
        eam_pkg::ADDR_LCYC_MODE: lcyc_mode_next = hwdata[7:0]; // [RL6] [RL8]
        eam_pkg::ADDR_THRESH: thresh_next = hwdata[7:0];
        default: ;
      endcase
    end
    // A set in the clearing cycle wins
    if (lc_enable && period_done) begin
      status_next[eam_pkg::ST_LDONE_BIT] = 1'b1; // [RL13]
    end
    if (aehf) begin
      status_next[eam_pkg::ST_AEHF_BIT] = 1'b1;
    end
    if (faehf) begin
      status_next[eam_pkg::ST_FAEHF_BIT] = 1'b1;
    end
    irq_n_next = ((status_next & mask_next) == 16'h0000); // [RL13]
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addr_reg <= '0;
      wr_pend_reg <= 1'b0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      half_cyc_reg <= eam_pkg::HALF_CYC_RST;
      comp_mode_reg <= eam_pkg::COMP_MODE_RST;
      acc_mode_reg <= eam_pkg::ACC_MODE_RST;
      lcyc_mode_reg <= eam_pkg::LCYC_MODE_RST;
      thresh_reg <= eam_pkg::THRESH_RST;
      status_reg <= eam_pkg::STATUS_MASK_RST;
      mask_reg <= eam_pkg::STATUS_MASK_RST;
      interrupt_line_0_n <= 1'b1;
    end else begin
      addr_reg <= addr_next;
      wr_pend_reg <= wr_pend_next;
      hrdata <= rdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      half_cyc_reg <= half_cyc_next;
      comp_mode_reg <= comp_mode_next;
      acc_mode_reg <= acc_mode_next;
      lcyc_mode_reg <= lcyc_mode_next;
      thresh_reg <= thresh_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      interrupt_line_0_n <= irq_n_next;
    end
  end

endmodule : eam_accum_ctrl

/* File: design/eam_first_stage.sv */
`timescale 1ns/1ps
module eam_first_stage #(
  parameter int PW = 48,
  parameter int AW = 56
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Power sample and rate
  input wire logic tick,
  input wire logic signed [PW-1:0] power,
  input wire logic [7:0] thresh,
  // Threshold pulses
  output logic pulse_pos,
  output logic pulse_neg
);

  logic signed [AW-1:0] acc_reg;
  logic signed [AW-1:0] acc_next;
  logic pos_next;
  logic neg_next;
  logic signed [AW-1:0] thr;
  logic signed [AW-1:0] sum;

  always_comb begin
    thr = AW'({thresh, {eam_pkg::THRESH_SHIFT{1'b0}}});
    sum = acc_reg + AW'(power);
    acc_next = acc_reg;
    pos_next = 1'b0;
    neg_next = 1'b0;
    if (tick) begin
      // Residue kept so no energy is lost between pulses
      if (sum >= thr) begin
        acc_next = sum - thr;
        pos_next = 1'b1;
      end else if (sum <= -thr) begin
        acc_next = sum + thr;
        neg_next = 1'b1;
      end else begin
        acc_next = sum;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_reg <= '0;
      pulse_pos <= 1'b0;
      pulse_neg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      pulse_pos <= pos_next;
      pulse_neg <= neg_next;
    end
  end

endmodule : eam_first_stage

/* File: design/eam_pkg.sv */
// Notes on behaviour
// [RL1] Wiring field bits 5:4: 00 per-phase, 01 B=A-C, 11 B=-A, 10 reserved.
// [RL2] Three-wire delta: phase B rms sees A minus C, phase B current zero.
// [RL3] Software clears bit 1 of each frequency-output term field in delta.
// [RL4] Method field bits 1:0 governs how active pulses are accumulated.
// [RL5] Line cycle mode copies accumulators after programmed half cycles.
// [RL6] Line cycle mode runs while bit 0 of line cycle mode register is one.
// [RL7] Software keeps read-clears-energy low while using line cycle mode.
// [RL8] Bits 5:3 pick which phases' zero crossings count, any combination.
// [RL9] Software selects one phase only for zero crossings during calibration.
// [RL10] Half-cycle count is 16-bit unsigned, up to 65,535 crossings.
// [RL11] Counter always runs, so first result after enable may be partial.
// [RL12] Half-cycle count write with line cycle enabled restarts counter.
// [RL13] Period end sets status bit 5; masked low interrupt; write one clears.
// [RL14] Line cycle uses same path and energy weight as normal accumulation.
// [RL15] Read-clears-energy set: watthour register returns to zero after read.
// [RL16] Pulses add into internal 32-bit registers that feed the transfers.
// [RL17] Period end restarts counter and clears accumulators with transfer.
package eam_pkg;

  localparam int ADDR_W = 18;
  localparam int NUM_CH = 6;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_ENERGY_BASE = 16'he400;
  localparam logic [15:0] IDX_EVENT_STATUS_0 = 16'he502;
  localparam logic [15:0] IDX_EVENT_MASK_0 = 16'he50a;
  localparam logic [15:0] IDX_HALF_CYC = 16'he60c;
  localparam logic [15:0] IDX_COMP_MODE = 16'he60e;
  localparam logic [15:0] IDX_ACC_MODE = 16'he701;
  localparam logic [15:0] IDX_LCYC_MODE = 16'he702;
  localparam logic [15:0] IDX_THRESH = 16'hea02;

  localparam logic [17:0] ADDR_ENERGY0 = {IDX_ENERGY_BASE, 2'b00};
  localparam logic [17:0] ADDR_STRIDE = 18'h00004;
  localparam logic [17:0] ADDR_EVENT_STATUS_0 = {IDX_EVENT_STATUS_0, 2'b00};
  localparam logic [17:0] ADDR_EVENT_MASK_0 = {IDX_EVENT_MASK_0, 2'b00};
  localparam logic [17:0] ADDR_HALF_CYC = {IDX_HALF_CYC, 2'b00};
  localparam logic [17:0] ADDR_COMP_MODE = {IDX_COMP_MODE, 2'b00};
  localparam logic [17:0] ADDR_ACC_MODE = {IDX_ACC_MODE, 2'b00};
  localparam logic [17:0] ADDR_LCYC_MODE = {IDX_LCYC_MODE, 2'b00};
  localparam logic [17:0] ADDR_THRESH = {IDX_THRESH, 2'b00};

  // Field positions
  localparam int WIRING_LSB = 4;
  localparam int METHOD_LSB = 0;
  localparam int LC_EN_BIT = 0;
  localparam int ZERO_CROSS_PHASE_SELECT_LSB = 3;
  localparam int RDCLR_BIT = 6;
  localparam int ST_AEHF_BIT = 0;
  localparam int ST_FAEHF_BIT = 1;
  localparam int ST_LDONE_BIT = 5;
  localparam int HALF_FULL_BIT = 30;
  localparam int THRESH_SHIFT = 27;

  // Wiring configurations
  localparam logic [1:0] WIRE_WYE = 2'h0;
  localparam logic [1:0] WIRE_DELTA3 = 2'h1;
  localparam logic [1:0] WIRE_DELTA4 = 2'h3;

  // Accumulation methods
  localparam logic [1:0] METH_SIGNED = 2'h0;
  localparam logic [1:0] METH_POSITIVE = 2'h1;
  localparam logic [1:0] METH_ABSOLUTE = 2'h3;

  // Reset values
  localparam logic [15:0] HALF_CYC_RST = 16'hffff;
  localparam logic [15:0] COMP_MODE_RST = 16'h0000;
  localparam logic [7:0] ACC_MODE_RST = 8'h00;
  localparam logic [7:0] LCYC_MODE_RST = 8'h38;
  localparam logic [7:0] THRESH_RST = 8'h03;
  localparam logic [15:0] STATUS_MASK_RST = 16'h0000;
  localparam logic [15:0] STATUS_USED = 16'h0023;

  // First-stage rate as a fractional divider, in kHz
  localparam int CLK_KHZ = 100000;
  localparam int FS_KHZ = 1024;
  localparam logic [16:0] DIV_MOD = 17'(CLK_KHZ);
  localparam logic [16:0] DIV_STEP = 17'(FS_KHZ);

  typedef struct packed {
    logic signed [23:0] volt;
    logic signed [23:0] curr;
  } eam_phase_s;

endpackage : eam_pkg

/* File: design/eam_zx_counter.sv */
`timescale 1ns/1ps
module eam_zx_counter (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Crossings and control
  input wire logic [2:0] zx_pulse,
  input wire logic [2:0] select,
  input wire logic [15:0] limit,
  input wire logic restart,
  // Period end
  output logic period_done
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic done_next;
  logic [2:0] hits;
  logic [16:0] total;

  always_comb begin
    hits = zx_pulse & select; // [RL8]
    total = {1'b0, cnt_reg} + 17'(hits[0]) + 17'(hits[1]) + 17'(hits[2]);
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (restart) begin
      cnt_next = '0; // [RL12]
    end else if (hits != 3'h0) begin
      // Counts regardless of line cycle enable [RL11]
      if (limit != 16'h0000 && total >= {1'b0, limit}) begin
        cnt_next = '0; // [RL17]
        done_next = 1'b1;
      end else begin
        cnt_next = total[15:0]; // [RL10]
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      period_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      period_done <= done_next;
    end
  end

endmodule : eam_zx_counter

/* File: tb/eam_accum_ctrl_sva.sv */
`timescale 1ns/1ps
module eam_accum_ctrl_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus
  input wire logic hsel,
  input wire logic [eam_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Samples
  input wire eam_pkg::eam_phase_s total_a,
  input wire eam_pkg::eam_phase_s total_b,
  input wire eam_pkg::eam_phase_s total_c,
  // Results
  input wire logic signed [23:0] phase_b_rms_voltage,
  input wire logic signed [23:0] phase_b_current,
  input wire logic interrupt_line_0_n
);
  logic dp_reg, dp_next, dpw_reg, dpw_next;
  logic [eam_pkg::ADDR_W-1:0] dpa_reg, dpa_next;
  logic [1:0] wir_reg, wir_next;
  logic [5:0] msk_reg, msk_next;
  logic wr_ok;

  // Shadow copies of wiring and mask, tracked from the bus
  assign wr_ok = dp_reg && dpw_reg && hready;
  always_comb begin
    dp_next = hsel && htrans[1] && hready;
    dpa_next = haddr;
    dpw_next = hwrite;
    wir_next = wir_reg;
    msk_next = msk_reg;
    if (wr_ok && dpa_reg == eam_pkg::ADDR_ACC_MODE) begin
      wir_next = hwdata[5:4];
    end
    if (wr_ok && dpa_reg == eam_pkg::ADDR_EVENT_MASK_0) begin
      msk_next = hwdata[5:0] & 6'h23;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dp_reg <= 1'b0;
      dpw_reg <= 1'b0;
      dpa_reg <= '0;
      wir_reg <= 2'h0;
      msk_reg <= 6'h00;
    end else begin
      dp_reg <= dp_next;
      dpw_reg <= dpw_next;
      dpa_reg <= dpa_next;
      wir_reg <= wir_next;
      msk_reg <= msk_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Stable inputs for two cycles tolerate one extra pipeline stage
  wye_rms_a: assert property (
    !wir_reg[0] && $stable(wir_reg) && $stable(total_b)
    |=> phase_b_rms_voltage == $past(total_b.volt))
    else $error("phase b voltage not per-phase");
  delta3_rms_a: assert property (
    wir_reg == 2'h1 && $stable(wir_reg) && $stable(total_a)
    && $stable(total_c) |=> phase_b_rms_voltage ==
    $past(total_a.volt) - $past(total_c.volt))
    else $error("phase b voltage not a minus c");
  delta4_rms_a: assert property (
    wir_reg == 2'h3 && $stable(wir_reg) && $stable(total_a)
    |=> phase_b_rms_voltage == -$past(total_a.volt))
    else $error("phase b voltage not minus a");
  delta3_curr_a: assert property (
    wir_reg == 2'h1 |=> phase_b_current == 24'sh0)
    else $error("phase b current not forced to zero");
  wye_curr_a: assert property (
    !wir_reg[0] && $stable(wir_reg) && $stable(total_b)
    |=> phase_b_current == $past(total_b.curr))
    else $error("phase b current not passed through");
  irq_masked_a: assert property (
    msk_reg == 6'h00 && $past(msk_reg) == 6'h00 |-> interrupt_line_0_n)
    else $error("interrupt low with all masks off");
  irq_cause_a: assert property (
    $fell(interrupt_line_0_n) |-> msk_reg != 6'h00)
    else $error("interrupt fell without a mask bit");
  half_cyc_width_a: assert property (
    dp_reg && !dpw_reg && dpa_reg == eam_pkg::ADDR_HALF_CYC
    |-> hrdata[31:16] == 16'h0000)
    else $error("half cycle count wider than 16 bits");

  delta3_c: cover property (wir_reg == 2'h1 ##1 wir_reg == 2'h1);
  irq_fall_c: cover property ($fell(interrupt_line_0_n));
  delta4_c: cover property (wir_reg == 2'h3 ##1 wir_reg == 2'h3);
endmodule : eam_accum_ctrl_chk

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    string nm;
  } eam_note_s;
  logic clock, reset, hsel, hwrite, hready, hreadyout, hresp, dp_read;
  logic [eam_pkg::ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, zero_cross_in;
  logic [31:0] hwdata, hrdata, r;
  logic [23:0] e_rms, e_cur;
  eam_pkg::eam_phase_s tot_a, tot_b, tot_c;
  logic signed [23:0] phase_b_rms_voltage, phase_b_current;
  logic interrupt_line_0_n;
  int miscompares, comparisons;
  eam_note_s notes[$];
  eam_note_s nt;

  assign hready = hreadyout;

  eam_accum_ctrl i_dut (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .total_a(tot_a), .total_b(tot_b), .total_c(tot_c),
    .fund_a(tot_a), .fund_b(tot_b), .fund_c(tot_c),
    .zero_cross_in(zero_cross_in),
    .phase_b_rms_voltage(phase_b_rms_voltage),
    .phase_b_current(phase_b_current),
    .interrupt_line_0_n(interrupt_line_0_n)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      close_out();
    end
  endtask : wait_ready

  // Single transfer; address phase held until ready, then data phase
  task automatic bus(input logic [17:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    dp_read <= ~w;
    wait_ready();
    dp_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [17:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string nm);
    notes.push_back('{e & m, m, nm});
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // Crossings are sign edges; each toggle is one crossing
  task automatic zx(input logic [2:0] b, input int n);
    repeat (n) begin
      zero_cross_in <= zero_cross_in ^ b;
      cyc(8);
    end
  endtask : zx

  task automatic irq_expect(input logic e);
    int n;
    n = 0;
    while (interrupt_line_0_n !== e && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk("interrupt_line_0_n", {31'h0, e}, {31'h0, interrupt_line_0_n});
  endtask : irq_expect

  function automatic logic [17:0] ea(input int i);
    return eam_pkg::ADDR_ENERGY0 + eam_pkg::ADDR_STRIDE * 18'(i);
  endfunction : ea

  // Small samples keep each tick below the pulse threshold: no backlog
  function automatic eam_pkg::eam_phase_s rnd();
    logic [14:0] v, c;
    v = 15'($urandom());
    c = 15'($urandom());
    return '{{{9{v[14]}}, v}, {{9{c[14]}}, c}};
  endfunction : rnd

  always @(posedge clock) begin
    if (dp_read === 1'b1 && hready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("note queue", 32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        chk(nt.nm, nt.exp, hrdata & nt.msk);
      end
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dp_read = 1'b0;
    zero_cross_in = 3'h0;
    tot_a = '0;
    tot_b = '0;
    tot_c = '0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(32'h4cb9));
    cyc(3);
    reset <= 1'b0;
    cyc(1);
    rd(eam_pkg::ADDR_HALF_CYC, 32'hffff, '1, "half_cycle_count");
    rd(eam_pkg::ADDR_COMP_MODE, 32'h0, '1, "computation_mode");
    rd(eam_pkg::ADDR_ACC_MODE, 32'h0, '1, "accumulation_mode");
    rd(eam_pkg::ADDR_LCYC_MODE, 32'h38, '1, "line_cycle_mode");
    rd(eam_pkg::ADDR_EVENT_STATUS_0, 32'h0, '1, "event_status_0");
    rd(eam_pkg::ADDR_EVENT_MASK_0, 32'h0, '1, "event_mask_0");
    for (int i = 0; i < 6; i++) rd(ea(i), 32'h0, '1, "energy");
    r = $urandom();
    bus(eam_pkg::ADDR_COMP_MODE, 1'b1, r);
    rd(eam_pkg::ADDR_COMP_MODE, {16'h0, r[15:0]}, '1, "comp");
    bus(eam_pkg::ADDR_HALF_CYC, 1'b1, r);
    rd(eam_pkg::ADDR_HALF_CYC, {16'h0, r[15:0]}, '1, "half");
    bus(ea(0), 1'b1, r);
    rd(ea(0), 32'h0, '1, "energy read-only");
    bus(18'h00100, 1'b1, r);
    rd(18'h00100, 32'h0, '1, "unmapped");
    // Negative power on phase c: positive-only drops it, signed keeps it
    tot_c <= '{24'h004000, 24'hffc000};
    bus(eam_pkg::ADDR_ACC_MODE, 1'b1, 32'h1);
    cyc(600);
    rd(ea(2), 32'h0, '1, "energy c positive only");
    bus(eam_pkg::ADDR_ACC_MODE, 1'b1, 32'h0);
    cyc(600);
    rd(ea(2), 32'h80000000, 32'h80000000, "energy c signed");
    for (int w = 0; w < 4; w++) begin
      tot_a <= rnd();
      tot_b <= rnd();
      tot_c <= rnd();
      bus(eam_pkg::ADDR_ACC_MODE, 1'b1, 32'(w << 4));
      cyc(3);
      e_rms = (w == 1) ? tot_a.volt - tot_c.volt :
              (w == 3) ? -tot_a.volt : tot_b.volt;
      e_cur = (w == 1) ? 24'h0 : tot_b.curr;
      chk("rms", {8'h0, e_rms}, {8'h0, phase_b_rms_voltage});
      chk("curr", {8'h0, e_cur}, {8'h0, phase_b_current});
    end
    tot_a <= '0;
    tot_b <= '0;
    tot_c <= '0;
    bus(eam_pkg::ADDR_LCYC_MODE, 1'b1, 32'h78);
    cyc(300);
    for (int i = 0; i < 6; i++) begin
      rd(ea(i), 32'h0, 32'h0, "energy clearing read");
      rd(ea(i), 32'h0, '1, "energy after clear");
    end
    bus(eam_pkg::ADDR_EVENT_MASK_0, 1'b1, 32'h20);
    bus(eam_pkg::ADDR_ACC_MODE, 1'b1, 32'h10);
    tot_a <= '{24'h004000, 24'h004000};
    tot_b <= '{24'h004000, 24'h004000};
    bus(eam_pkg::ADDR_LCYC_MODE, 1'b1, 32'h09);
    bus(eam_pkg::ADDR_HALF_CYC, 1'b1, 32'h4);
    zx(3'b001, 3);
    irq_expect(1'b1);
    rd(ea(0), 32'h0, '1, "energy a before period end");
    bus(eam_pkg::ADDR_HALF_CYC, 1'b1, 32'h4);
    zx(3'b001, 3);
    irq_expect(1'b1);
    zx(3'b001, 1);
    irq_expect(1'b0);
    rd(eam_pkg::ADDR_EVENT_STATUS_0, 32'h20, 32'h20, "status done");
    rd(ea(1), 32'h0, '1, "energy b in delta");
    rd(ea(0), 32'h0, 32'h80000000, "energy a sign");
    bus(eam_pkg::ADDR_EVENT_STATUS_0, 1'b1, 32'h20);
    irq_expect(1'b1);
    bus(eam_pkg::ADDR_LCYC_MODE, 1'b1, 32'h11);
    zx(3'b101, 4);
    irq_expect(1'b1);
    bus(eam_pkg::ADDR_EVENT_MASK_0, 1'b1, 32'h0);
    bus(eam_pkg::ADDR_LCYC_MODE, 1'b1, 32'h29);
    bus(eam_pkg::ADDR_HALF_CYC, 1'b1, 32'h4);
    zx(3'b001, 2);
    zx(3'b100, 2);
    irq_expect(1'b1);
    rd(eam_pkg::ADDR_EVENT_STATUS_0, 32'h20, 32'h20, "status a and c");
    bus(eam_pkg::ADDR_EVENT_MASK_0, 1'b1, 32'h20);
    irq_expect(1'b0);
    bus(eam_pkg::ADDR_EVENT_STATUS_0, 1'b1, 32'h20);
    irq_expect(1'b1);
    cyc(2);
    close_out();
  end
endmodule : tb

bind eam_accum_ctrl eam_accum_ctrl_chk i_chk (
  .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .total_a(total_a), .total_b(total_b),
  .total_c(total_c), .phase_b_rms_voltage(phase_b_rms_voltage),
  .phase_b_current(phase_b_current),
  .interrupt_line_0_n(interrupt_line_0_n)
);
